// ### hdl/sac_pkg.sv
// Functional notes
// [RL1] Eight-bit result by successive approximation
// [RL2] Each step advances on conversion clock
// [RL3] Clock select: /2, /8, /32, RC
// [RL4] Sleep conversions only with RC clock
// [RL5] Channel select field in bits 5:3
// [RL6] Writing go starts; hardware clears on finish
// [RL7] Finish: load result, clear go, flag
// [RL8] Enable bit powers converter; off draws nothing
// [RL9] Unimplemented bits ignore writes, read zero
// [RL10] Control registers reset to zero
// [RL11] Codes 001/011/101 take external reference
// [RL12] Port field maps analog and digital pins
// [RL13] Software waits acquisition before starting
// [RL14] Hold capacitor disconnected two periods after
// [RL15] Hold capacitor never discharged by device
// [RL16] Software polls go or awaits flag
// [RL17] Flag stays set until software clears
// [RL18] Software sets analog pins as inputs
// [RL19] Conversion lasts nine and half periods
// [RL20] Clearing go aborts, waits, reacquires
// [RL21] Software keeps period above minimum
// [RL22] Start ignored while module disabled
// [RL23] Divider counter; RC clock synchronised
package sac_pkg;

	// ==========================================================
	// Register map, word index; byte address is four times it
	// ==========================================================
	localparam logic [7:0] SAC_IDX_CTRL   = 8'h1f;
	localparam logic [7:0] SAC_IDX_PCFG   = 8'h9f;
	localparam logic [7:0] SAC_IDX_RESULT = 8'h1e;
	localparam logic [7:0] SAC_IDX_IRQ    = 8'h20;

	// ==========================================================
	// Fields and reset values
	// ==========================================================
	localparam int         SAC_BIT_EN    = 0;
	localparam int         SAC_BIT_GO    = 2;
	localparam int         SAC_CH_LSB    = 3;
	localparam int         SAC_CS_LSB    = 6;
	localparam logic [7:0] SAC_CTRL_WMSK = 8'hfd;
	localparam logic [7:0] SAC_CTRL_RST  = 8'h00;
	localparam logic [2:0] SAC_PCFG_RST  = 3'h0;
	localparam logic [7:0] SAC_RES_RST   = 8'h00;

	// ==========================================================
	// Conversion clock select codes and half-period terminals
	// ==========================================================
	localparam logic [1:0] SAC_CS_DIV2  = 2'h0;
	localparam logic [1:0] SAC_CS_DIV8  = 2'h1;
	localparam logic [1:0] SAC_CS_DIV32 = 2'h2;
	localparam logic [1:0] SAC_CS_RC    = 2'h3;
	localparam logic [3:0] SAC_HALF_DIV2  = 4'h0;
	localparam logic [3:0] SAC_HALF_DIV8  = 4'h3;
	localparam logic [3:0] SAC_HALF_DIV32 = 4'hf;

	// ==========================================================
	// Sequence counts in half conversion periods
	// ==========================================================
	localparam logic [4:0] SAC_FIRST_TRIAL = 5'h03;
	localparam logic [4:0] SAC_LAST_HALF   = 5'h12;
	localparam logic [4:0] SAC_WAIT_LAST   = 5'h03;

	typedef enum logic [1:0] {
		SAC_IDLE,
		SAC_CONV,
		SAC_WAIT
	} sac_state_e;

endpackage

// ### hdl/sac_tick_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sac_tick_if;
	logic       run;
	logic [1:0] sel;
	logic       sleep;
	logic       half_tick;

	modport ctl (output run, output sel, output sleep, input half_tick);
	modport gen (input run, input sel, input sleep, output half_tick);
endinterface
`default_nettype wire

// ### hdl/sac_tad_div.sv
`timescale 1ns/1ps
`default_nettype none
module sac_tad_div
	import sac_pkg::*;
(
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic resetn_i,
	// Free-running RC oscillator pin
	input  wire logic rc_clk_i,
	// Tick link to the sequencer
	sac_tick_if.gen   tk
);

	typedef struct packed {
		logic [3:0] cnt;
		logic [2:0] rc;
		logic       tick;
	} sac_div_s;

	sac_div_s   r_ff;
	sac_div_s   nxt_r;
	logic [3:0] lim;
	logic       osc_ok;

	// ==========================================================
	// Half-period enable generation
	// ==========================================================
	always_comb
	begin
		nxt_r = r_ff;
		nxt_r.rc = {r_ff.rc[1:0], rc_clk_i}; // [RL23]
		unique case (tk.sel) // [RL3]
			SAC_CS_DIV2:  lim = SAC_HALF_DIV2;
			SAC_CS_DIV8:  lim = SAC_HALF_DIV8;
			default:      lim = SAC_HALF_DIV32;
		endcase
		// Oscillator stops in sleep; only the RC source keeps going
		osc_ok = !tk.sleep || (tk.sel == SAC_CS_RC); // [RL4]
		nxt_r.tick = 1'b0;
		if (!tk.run)
		begin
			nxt_r.cnt = 4'h0;
		end
		else if (tk.sel == SAC_CS_RC)
		begin
			// Each settled RC edge is half a period
			nxt_r.tick = r_ff.rc[1] ^ r_ff.rc[2]; // [RL23]
		end
		else if (osc_ok)
		begin
			nxt_r.tick = (r_ff.cnt == lim); // [RL23]
			nxt_r.cnt = (r_ff.cnt == lim) ? 4'h0 : r_ff.cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			r_ff <= '0;
		else
			r_ff <= nxt_r;
	end

	assign tk.half_tick = r_ff.tick;

	// ==========================================================
	// Checks
	// ==========================================================
	a_sleep_stall: assert property (@(posedge clk_i) // [RL4]
		disable iff (!resetn_i)
		(tk.sleep && tk.sel != SAC_CS_RC) |=> !tk.half_tick)
		else $error("Tick while oscillator stopped in sleep");

	a_div8_spacing: assert property (@(posedge clk_i) // [RL3]
		disable iff (!resetn_i)
		(tk.half_tick && tk.run && !tk.sleep && tk.sel == SAC_CS_DIV8
		&& $stable(tk.sel)) |=> !tk.half_tick [*3])
		else $error("Divide by eight half period too short");

endmodule
`default_nettype wire

// ### hdl/sac_top.sv
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module sac_top
	import sac_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	// Avalon-MM slave, byte address
	input  wire logic [9:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	// Device state
	input  wire logic        sleep_i,
	input  wire logic        rc_clk_i,
	// Analog front end
	input  wire logic        cmp_i,
	output logic             analog_en_o,
	output logic      [2:0]  channel_o,
	output logic             hold_connect_o,
	output logic      [7:0]  trial_code_o,
	output logic             ref_ext_o,
	output logic      [7:0]  pin_analog_o,
	// Status
	output logic             irq_flag_o,
	output logic             busy_o
);

	typedef struct packed {
		sac_state_e st;
		logic [7:0] ctrl;
		logic [2:0] pcfg;
		logic [7:0] result;
		logic       irq;
		logic [7:0] trial;
		logic [4:0] hcnt;
		logic       ack;
		logic [7:0] rdata;
	} sac_regs_s;

	sac_regs_s  r_ff;
	sac_regs_s  nxt_r;
	sac_tick_if tk ();

	logic       req;
	logic       wr_ok;
	logic [7:0] idx;
	logic [7:0] wbyte;
	logic [4:0] off;
	logic [2:0] bi;
	logic [7:0] decided;
	logic       done_evt;
	logic       abort_evt;

	assign req   = avs_read_i || avs_write_i;
	assign idx   = avs_address_i[9:2];
	assign wbyte = avs_writedata_i[7:0];
	// Write lands only on the edge where waitrequest is low
	assign wr_ok = avs_write_i && r_ff.ack && avs_byteenable_i[0];
	assign off   = r_ff.hcnt - SAC_FIRST_TRIAL;
	assign bi    = 3'h7 - off[3:1];

	// ==========================================================
	// Conversion clock divider
	// ==========================================================
	assign tk.run   = r_ff.ctrl[SAC_BIT_EN];
	assign tk.sel   = r_ff.ctrl[SAC_CS_LSB +: 2];
	assign tk.sleep = sleep_i;

	sac_tad_div u_sac_tad_div (
		.clk_i    (clk_i),
		.resetn_i (resetn_i),
		.rc_clk_i (rc_clk_i),
		.tk       (tk)
	);

	// ==========================================================
	// Register access and sequencer
	// ==========================================================
	always_comb
	begin
		nxt_r = r_ff;
		done_evt = 1'b0;
		abort_evt = 1'b0;
		decided = r_ff.trial;
		nxt_r.ack = req && !r_ff.ack;
		if (req && !r_ff.ack)
		begin
			unique case (idx)
				SAC_IDX_CTRL:   nxt_r.rdata = r_ff.ctrl;
				SAC_IDX_PCFG:   nxt_r.rdata = {5'h00, r_ff.pcfg}; // [RL9]
				SAC_IDX_RESULT: nxt_r.rdata = r_ff.result;
				SAC_IDX_IRQ:    nxt_r.rdata = {7'h00, r_ff.irq};
				default:        nxt_r.rdata = 8'h00;
			endcase
		end
		if (wr_ok)
		begin
			unique case (idx)
				SAC_IDX_CTRL:
				begin
					nxt_r.ctrl = wbyte & SAC_CTRL_WMSK; // [RL9]
					// A start with the module off is dropped
					if (!wbyte[SAC_BIT_EN])
						nxt_r.ctrl[SAC_BIT_GO] = 1'b0; // [RL22]
				end
				SAC_IDX_PCFG:   nxt_r.pcfg = wbyte[2:0];
				SAC_IDX_RESULT: nxt_r.result = wbyte;
				SAC_IDX_IRQ:    nxt_r.irq = wbyte[0]; // [RL17]
				default:        nxt_r.rdata = r_ff.rdata;
			endcase
		end
		unique case (r_ff.st)
			SAC_IDLE:
			begin
				nxt_r.hcnt = 5'h00;
				if (nxt_r.ctrl[SAC_BIT_GO]) // [RL6]
				begin
					nxt_r.st = SAC_CONV;
					nxt_r.trial = 8'h00;
				end
			end
			SAC_CONV:
			begin
				if (!nxt_r.ctrl[SAC_BIT_GO])
				begin
					// Partial code is dropped, result kept
					abort_evt = 1'b1;
					nxt_r.st = SAC_WAIT; // [RL20]
					nxt_r.hcnt = 5'h00;
				end
				else if (tk.half_tick) // [RL2]
				begin
					nxt_r.hcnt = r_ff.hcnt + 5'h01;
					if (r_ff.hcnt >= SAC_FIRST_TRIAL && r_ff.hcnt[0])
						nxt_r.trial[bi] = 1'b1; // [RL1]
					else if (r_ff.hcnt > SAC_FIRST_TRIAL)
					begin
						decided[bi] = cmp_i; // [RL1]
						nxt_r.trial = decided;
					end
					if (r_ff.hcnt == SAC_LAST_HALF) // [RL19]
					begin
						done_evt = 1'b1;
						nxt_r.result = decided; // [RL7]
						nxt_r.ctrl[SAC_BIT_GO] = 1'b0; // [RL6]
						nxt_r.irq = 1'b1; // [RL7]
						nxt_r.st = SAC_WAIT;
						nxt_r.hcnt = 5'h00;
					end
				end
			end
			SAC_WAIT:
			begin
				// Hold stays off the input for two periods
				if (tk.half_tick) // [RL14]
				begin
					nxt_r.hcnt = r_ff.hcnt + 5'h01;
					if (r_ff.hcnt == SAC_WAIT_LAST)
						nxt_r.st = SAC_IDLE; // [RL20]
				end
			end
		endcase
		if (!nxt_r.ctrl[SAC_BIT_EN])
		begin
			nxt_r.st = SAC_IDLE; // [RL8]
			nxt_r.hcnt = 5'h00;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			r_ff <= '0;
			r_ff.st <= SAC_IDLE;
			r_ff.ctrl <= SAC_CTRL_RST; // [RL10]
			r_ff.pcfg <= SAC_PCFG_RST; // [RL10]
			r_ff.result <= SAC_RES_RST;
		end
		else
		begin
			r_ff <= nxt_r;
		end
	end

	// ==========================================================
	// Outputs
	// ==========================================================
	assign avs_readdata_o    = {24'h00_0000, r_ff.rdata};
	assign avs_waitrequest_o = req && !r_ff.ack;
	assign analog_en_o       = r_ff.ctrl[SAC_BIT_EN]; // [RL8]
	assign channel_o         = r_ff.ctrl[SAC_CH_LSB +: 3]; // [RL5]
	// No discharge path: the cap simply floats between samples
	assign hold_connect_o    = r_ff.ctrl[SAC_BIT_EN]
		&& (r_ff.st == SAC_IDLE); // [RL15]
	assign trial_code_o      = r_ff.trial;
	assign irq_flag_o        = r_ff.irq;
	assign busy_o            = (r_ff.st == SAC_CONV);
	assign ref_ext_o         = r_ff.pcfg[0] && (r_ff.pcfg[2:1] != 2'h3); // [RL11]

	always_comb
	begin
		unique case (r_ff.pcfg) // [RL12]
			3'h0:    pin_analog_o = 8'hff;
			3'h1:    pin_analog_o = 8'hf7;
			3'h2:    pin_analog_o = 8'h1f;
			3'h3:    pin_analog_o = 8'h17;
			3'h4:    pin_analog_o = 8'h0b;
			3'h5:    pin_analog_o = 8'h03;
			default: pin_analog_o = 8'h00;
		endcase
	end

	// ==========================================================
	// Checks
	// ==========================================================
	logic [4:0] chk_halves;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			chk_halves <= 5'h00;
		else if (r_ff.st != SAC_CONV)
			chk_halves <= 5'h00;
		else if (tk.half_tick)
			chk_halves <= chk_halves + 5'h01;
	end

	a_conv_length: assert property (@(posedge clk_i) // [RL19]
		disable iff (!resetn_i)
		done_evt |-> (chk_halves == SAC_LAST_HALF) && tk.half_tick)
		else $error("Conversion not nine and a half periods");

	a_done_effects: assert property (@(posedge clk_i) // [RL7]
		disable iff (!resetn_i)
		done_evt |=> irq_flag_o && !r_ff.ctrl[SAC_BIT_GO]
		&& (r_ff.result == $past(decided)))
		else $error("Completion did not load result and flags");

	a_abort_keeps: assert property (@(posedge clk_i) // [RL20]
		disable iff (!resetn_i)
		abort_evt |=> $stable(r_ff.result) && !busy_o)
		else $error("Abort changed result or kept converting");

	a_hold_gap: assert property (@(posedge clk_i) // [RL14]
		disable iff (!resetn_i)
		done_evt |=> !hold_connect_o [*2])
		else $error("Hold reconnected right after conversion");

	a_go_needs_en: assert property (@(posedge clk_i) // [RL22]
		disable iff (!resetn_i)
		r_ff.ctrl[SAC_BIT_GO] |-> r_ff.ctrl[SAC_BIT_EN])
		else $error("Go set while module disabled");

	a_off_idle: assert property (@(posedge clk_i) // [RL8]
		disable iff (!resetn_i)
		!analog_en_o |-> (r_ff.st == SAC_IDLE) && !hold_connect_o)
		else $error("Converter active while disabled");

	a_reserved_zero: assert property (@(posedge clk_i) // [RL9]
		disable iff (!resetn_i)
		(avs_read_i && !avs_waitrequest_o && idx == SAC_IDX_CTRL)
		|-> avs_readdata_o[1] == 1'b0)
		else $error("Unimplemented control bit read as one");

	a_step_on_tick: assert property (@(posedge clk_i) // [RL2]
		disable iff (!resetn_i)
		(busy_o && !tk.half_tick) |=> $stable(r_ff.trial) || !busy_o
		|| $past(r_ff.st) != SAC_CONV)
		else $error("Approximation step without conversion tick");

	a_irq_sticky: assert property (@(posedge clk_i) // [RL17]
		disable iff (!resetn_i)
		(irq_flag_o && !(wr_ok && idx == SAC_IDX_IRQ)) |=> irq_flag_o)
		else $error("Flag cleared without software write");

	a_trial_clear: assert property (@(posedge clk_i) // [RL1]
		disable iff (!resetn_i)
		$rose(busy_o) |-> trial_code_o == 8'h00)
		else $error("Conversion began with stale trial code");

	a_sleep_freeze: assert property (@(posedge clk_i) // [RL4]
		disable iff (!resetn_i)
		(busy_o && sleep_i && $stable(sleep_i) && tk.sel != SAC_CS_RC
		&& $stable(tk.sel) && !wr_ok) |=> $stable(r_ff.hcnt))
		else $error("Conversion stepped in sleep without RC clock");

	a_ref_select: assert property (@(posedge clk_i) // [RL11]
		disable iff (!resetn_i)
		ref_ext_o == (r_ff.pcfg inside {3'h1, 3'h3, 3'h5}))
		else $error("Reference source does not follow pin config");

	a_all_digital: assert property (@(posedge clk_i) // [RL12]
		disable iff (!resetn_i)
		(r_ff.pcfg[2:1] == 2'h3) |-> pin_analog_o == 8'h00)
		else $error("Analog pin left in all digital config");

endmodule
`default_nettype wire

// ### test/sac_afe_model.sv
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model
	import sac_pkg::*;
(
	// Clock and front-end controls
	input  wire logic       clk_i,
	input  wire logic       en_i,
	input  wire logic [2:0] ch_i,
	input  wire logic       hold_i,
	input  wire logic [7:0] trial_i,
	input  wire logic [7:0] lvl_i [8],
	// Comparator
	output logic            cmp_o
);
	// ======
	// Hold capacitor
	// ======
	logic [7:0] cap = 8'h00;
	logic       junk = 1'b0;

	always @(posedge clk_i)
	begin
		junk <= ~junk;
		// Charge kept while disconnected, never dumped
		if (en_i && hold_i)
			cap <= lvl_i[ch_i];
	end

	// Settles at once, so any period is long enough; unpowered toggles
	assign cmp_o = en_i ? (cap >= trial_i) : junk;
endmodule
`default_nettype wire

// ### test/sac_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top_tb
	import sac_pkg::*;
;
	// ======
	// Stimulus and wiring
	// ======
	logic        clk = 1'b0, rstn = 1'b0, rd = 1'b0, wr = 1'b0;
	logic        slp = 1'b0, rc = 1'b0;
	logic [9:0]  addr = 10'h000;
	logic [3:0]  be = 4'h0;
	logic [31:0] wd = 32'h0000_0000;
	logic [31:0] rdat;
	logic        wreq, cmp, aen, hold, rext, irq, busy;
	logic [2:0]  ch;
	logic [7:0]  trial, pan, v;
	logic [7:0]  lv [8] = '{8'h00, 8'hff, 8'h80, 8'h7f, 8'h01, 8'hfe, 8'h55, 8'haa};
	logic [7:0]  pm [8] = '{8'hff, 8'hf7, 8'h1f, 8'h17, 8'h0b, 8'h03, 8'h00, 8'h00};
	logic [7:0]  rx = 8'h2a;
	int          n_errors = 0, n_tests = 0, bc = 0, hc = 0;

	always #4 clk = ~clk;
	// RC pin free-running, unrelated in phase to clk
	always #29.7 rc = ~rc;
	// Snapshots instead of resets avoid two drivers on the counts
	always @(posedge clk)
	begin
		bc <= bc + int'(busy === 1'b1);
		hc <= hc + int'(aen === 1'b1 && busy === 1'b0 && hold === 1'b0);
	end

	sac_top u_sac_top (.clk_i(clk), .resetn_i(rstn), .avs_address_i(addr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_byteenable_i(be),
		.avs_writedata_i(wd), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
		.sleep_i(slp), .rc_clk_i(rc), .cmp_i(cmp), .analog_en_o(aen),
		.channel_o(ch), .hold_connect_o(hold), .trial_code_o(trial),
		.ref_ext_o(rext), .pin_analog_o(pan), .irq_flag_o(irq), .busy_o(busy));
	sac_afe_model u_sac_afe_model (.clk_i(clk), .en_i(aen), .ch_i(ch),
		.hold_i(hold), .trial_i(trial), .lvl_i(lv), .cmp_o(cmp));

	// ======
	// Tasks
	// ======
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
	begin
		n_tests++;
		if (s !== e)
		begin
			n_errors++;
			$display("ERROR %0t: saw %h expected %h", $time, s, e);
		end
	end
	endtask

	task automatic acc(input logic w, input logic [7:0] i, input logic [7:0] d,
		input logic [3:0] b);
	begin
		@(posedge clk);
		addr <= {i, 2'b00};
		wr <= w;
		rd <= !w;
		be <= b;
		wd <= {24'h00_0000, d};
		@(posedge clk);
		while (wreq !== 1'b0)
			@(posedge clk);
		v = rdat[7:0];
		rd <= 1'b0;
		wr <= 1'b0;
	end
	endtask

	task automatic rchk(input logic [7:0] i, input logic [7:0] e);
	begin
		acc(1'b0, i, 8'h00, 4'hf);
		chk(v, e);
	end
	endtask

	task automatic tdone(input string s);
	begin
		$display("Test %s done", s);
	end
	endtask

	task automatic conv(input logic [1:0] cs, input logic [2:0] c);
		int h, b0, h0;
	begin
		h = (cs == SAC_CS_DIV2) ? 1 : (cs == SAC_CS_DIV8) ? 4 : 16;
		acc(1'b1, SAC_IDX_CTRL, {cs, c, 3'b001}, 4'h1);
		// Acquisition time before start
		repeat (24) @(posedge clk);
		acc(1'b1, SAC_IDX_IRQ, 8'h00, 4'h1);
		b0 = bc;
		h0 = hc;
		acc(1'b1, SAC_IDX_CTRL, {cs, c, 3'b101}, 4'h1);
		@(posedge clk);
		chk({7'h00, busy}, 8'h01);
		chk({5'h00, ch}, {5'h00, c});
		v = 8'h04;
		for (int k = 0; k < 400 && v[2] !== 1'b0; k++)
			acc(1'b0, SAC_IDX_CTRL, 8'h00, 4'h1);
		chk(v, {cs, c, 3'b001});
		chk({7'h00, irq}, 8'h01);
		rchk(SAC_IDX_RESULT, lv[c]);
		repeat (5 * h + 8) @(posedge clk);
		chk({7'h00, hold}, 8'h01);
		chk({7'h00, irq}, 8'h01);
		if (cs != SAC_CS_RC)
		begin
			chk({7'h00, bc - b0 > 18 * h && bc - b0 <= 19 * h}, 8'h01);
			chk({7'h00, hc - h0 == 4 * h}, 8'h01);
		end
	end
	endtask

	task automatic give_verdict;
	begin
		$display("Checks %0d, mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	end
	endtask

	// ======
	// Tests
	// ======
	initial
	begin
		repeat (12) @(posedge clk);
		rstn <= 1'b1;
		rchk(SAC_IDX_CTRL, SAC_CTRL_RST);
		rchk(SAC_IDX_PCFG, 8'h00);
		rchk(SAC_IDX_IRQ, 8'h00);
		chk(pan, 8'hff);
		chk({7'h00, aen}, 8'h00);
		tdone("reset");
		acc(1'b1, SAC_IDX_CTRL, 8'h3a, 4'h1);
		rchk(SAC_IDX_CTRL, 8'h38);
		acc(1'b1, SAC_IDX_PCFG, 8'hff, 4'h1);
		rchk(SAC_IDX_PCFG, 8'h07);
		acc(1'b1, SAC_IDX_PCFG, 8'h05, 4'h0);
		acc(1'b1, 8'h40, 8'h11, 4'h1);
		rchk(SAC_IDX_PCFG, 8'h07);
		rchk(8'h40, 8'h00);
		for (int c = 0; c < 8; c++)
		begin
			acc(1'b1, SAC_IDX_PCFG, 8'(c), 4'h1);
			@(posedge clk);
			chk(pan, pm[c]);
			chk({7'h00, rext}, {7'h00, rx[c]});
		end
		tdone("registers");
		for (int k = 0; k < 8; k++)
			conv(2'(k % 3), 3'(k));
		tdone("conversions");
		slp <= 1'b1;
		acc(1'b1, SAC_IDX_CTRL, {SAC_CS_DIV8, 3'h2, 3'b001}, 4'h1);
		repeat (24) @(posedge clk);
		acc(1'b1, SAC_IDX_CTRL, {SAC_CS_DIV8, 3'h2, 3'b101}, 4'h1);
		repeat (200) @(posedge clk);
		chk({7'h00, busy}, 8'h01);
		acc(1'b1, SAC_IDX_CTRL, 8'h00, 4'h1);
		@(posedge clk);
		chk({6'h00, busy, aen}, 8'h00);
		conv(SAC_CS_RC, 3'h3);
		slp <= 1'b0;
		tdone("sleep");
		acc(1'b1, SAC_IDX_RESULT, 8'h3c, 4'h1);
		rchk(SAC_IDX_RESULT, 8'h3c);
		acc(1'b1, SAC_IDX_IRQ, 8'h00, 4'h1);
		rchk(SAC_IDX_IRQ, 8'h00);
		acc(1'b1, SAC_IDX_CTRL, {SAC_CS_DIV32, 3'h1, 3'b001}, 4'h1);
		repeat (24) @(posedge clk);
		acc(1'b1, SAC_IDX_CTRL, {SAC_CS_DIV32, 3'h1, 3'b101}, 4'h1);
		repeat (60) @(posedge clk);
		acc(1'b1, SAC_IDX_CTRL, {SAC_CS_DIV32, 3'h1, 3'b001}, 4'h1);
		@(posedge clk);
		chk({6'h00, busy, hold}, 8'h00);
		repeat (80) @(posedge clk);
		chk({6'h00, irq, hold}, 8'h01);
		rchk(SAC_IDX_RESULT, 8'h3c);
		tdone("abort");
		acc(1'b1, SAC_IDX_CTRL, 8'h04, 4'h1);
		@(posedge clk);
		chk({7'h00, busy}, 8'h00);
		rchk(SAC_IDX_CTRL, 8'h00);
		tdone("disabled start");
		give_verdict;
	end

	// Whole run needs well under ten thousand cycles
	initial
	begin
		repeat (30000) @(posedge clk);
		n_errors++;
		give_verdict;
	end
endmodule
`default_nettype wire
